/* File: dv/host_model.sv */
// host side model that writes the mode register and makes serial accesses
`timescale 1ns/1ps
module host_model (
   // clock
   input wire logic clk,
   // mode register write
   output logic mode_wr,
   output logic [7:0] mode_wr_addr,
   output logic [2:0] mode_wr_field,
   output logic mode_wr_clk_off,
   // serial access
   output logic serial_access
);
   initial begin
      mode_wr = 1'h0;
      mode_wr_addr = 8'h00;
      mode_wr_field = 3'h0;
      mode_wr_clk_off = 1'h0;
      serial_access = 1'h0;
   end

   // one-cycle write; address bit 1 carries the channel
   task automatic write_mode(input logic [7:0] a, input logic [2:0] f, input logic c);
      @(negedge clk);
      mode_wr <= 1'h1;
      mode_wr_addr <= a;
      mode_wr_field <= f;
      mode_wr_clk_off <= c;
      @(negedge clk);
      mode_wr <= 1'h0;
      mode_wr_addr <= ~a;
      mode_wr_field <= ~f;
      mode_wr_clk_off <= ~c;
   endtask : write_mode

   task automatic poke;
      @(negedge clk);
      serial_access <= 1'h1;
      @(negedge clk);
      serial_access <= 1'h0;
   endtask : poke
endmodule : host_model

/* File: dv/tb.sv */
// self-checking bench of the operating-mode sequencer
`timescale 1ns/1ps
module tb;
   logic clk = 1'h0;
   logic srst = 1'h1;
   logic [1:0] ch_enable = 2'h0;
   logic [15:0] t0 = 16'h0003;
   logic [15:0] t1 = 16'h0005;
   logic [15:0] rnd = 16'h5a06;
   logic mode_wr, mode_wr_clk_off, serial_access, ch;
   logic [7:0] mode_wr_addr;
   logic [2:0] mode_wr_field, operating_mode_field;
   logic master_clock_output_off, ready_n, serial_ack, conv_active, conv_channel;
   logic analog_power_down, inputs_shorted, data_update, zero_cal_update, full_cal_update, self_cal_update;
   logic [1:0] ch_ready, rdy;
   int err_count = 0;
   int n_tests = 0;
   int cyc = 0;
   int k, gap;

   always #4 clk = ~clk;

   host_model host_model_inst (.clk, .mode_wr, .mode_wr_addr, .mode_wr_field, .mode_wr_clk_off, .serial_access);
   mode_seq mode_seq_inst (.clk, .srst, .mode_wr, .mode_wr_addr, .mode_wr_field, .mode_wr_clk_off,
      .serial_access, .ch_enable, .ch0_conv_cycles(t0), .ch1_conv_cycles(t1), .operating_mode_field,
      .master_clock_output_off, .ch_ready, .ready_n, .serial_ack, .conv_active, .conv_channel,
      .analog_power_down, .inputs_shorted, .data_update, .zero_cal_update, .full_cal_update, .self_cal_update);

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next

   task automatic print_verdict;
      if (err_count == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : print_verdict

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask : chk

   function automatic logic strobe(input logic [2:0] f);
      case (f)
         3'h4: return self_cal_update;
         3'h6: return zero_cal_update;
         3'h7: return full_cal_update;
         default: return data_update;
      endcase
   endfunction : strobe

   // single conversion or calibration, timed from the write edge
   task automatic op(input logic [2:0] f, input logic c_sel, input logic c);
      int n;
      int j;
      n = c_sel ? int'(t1) : int'(t0);
      host_model_inst.write_mode(c_sel ? mode_seq_pkg::ADDR_MODE_HI : mode_seq_pkg::ADDR_MODE_LO, f, c);
      @(negedge clk);
      chk("mode", 16'(f), 16'(operating_mode_field));
      chk("ready_n", 16'h1, 16'(ready_n));
      chk("clk_off", 16'(c), 16'(master_clock_output_off));
      j = 1;
      while (strobe(f) !== 1'h1 && j < 200) begin
         @(negedge clk);
         j++;
         if (j == 2) begin
            chk("channel", 16'(c_sel), 16'(conv_channel));
            chk("shorted", 16'(f == 3'h4), 16'(inputs_shorted));
         end
      end
      chk("length", 16'(n + 2), 16'(j));
      chk("ch_ready", (f == 3'h2) ? 16'(2'h1 << c_sel) : 16'h0003, 16'(ch_ready));
      chk("ready_n end", 16'h0, 16'(ready_n));
      chk("mode end", 16'h0, 16'(operating_mode_field));
   endtask : op

   always @(posedge clk) begin
      cyc++;
      if (cyc > 3000) begin
         err_count++;
         print_verdict();
      end
   end

   initial begin
      repeat (4) @(negedge clk);
      srst = 1'h0;
      chk("reset mode", 16'h0, 16'(operating_mode_field));
      chk("reset ready", 16'h1, 16'({ch_ready, ready_n}));
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr_next(rnd);
         t0 = {13'h0, rnd[2:0]} + 16'h1;
         t1 = {13'h0, rnd[5:3]} + 16'h1;
         ch_enable = rnd[7:6];
         op(3'h2, rnd[8], rnd[9]);
         op(i[0] ? 3'h6 : 3'h7, rnd[10], rnd[11]);
         op(3'h4, rnd[12], rnd[13]);
      end
      // continuous: channels alternate, each period is its time plus a restart and a hand-over cycle
      ch_enable = 2'h3;
      host_model_inst.write_mode(mode_seq_pkg::ADDR_MODE_HI, 3'h1, 1'h0);
      ch = 1'h1;
      gap = int'(t1) + 2;
      rdy = 2'h0;
      repeat (5) begin
         k = 0;
         do begin
            @(negedge clk);
            k++;
         end while (data_update !== 1'h1 && k < 200);
         rdy[ch] = 1'h1;
         chk("cont gap", 16'(gap), 16'(k));
         chk("cont ready", 16'(rdy), 16'(ch_ready));
         chk("cont mode", 16'h1, 16'(operating_mode_field));
         ch = ~ch;
         gap = (ch ? int'(t1) : int'(t0)) + 2;
      end
      host_model_inst.write_mode(mode_seq_pkg::ADDR_MODE_LO, 3'h0, 1'h0);
      @(negedge clk);
      chk("abort", 16'h2, 16'({ch_ready, ready_n, conv_active}));
      host_model_inst.write_mode(mode_seq_pkg::ADDR_MODE_LO, 3'h3, 1'h1);
      @(negedge clk);
      chk("standby", 16'h3, 16'({analog_power_down, master_clock_output_off}));
      host_model_inst.poke();
      chk("serial ack", 16'h1, 16'(serial_ack));
      host_model_inst.write_mode(mode_seq_pkg::ADDR_MODE_LO, 3'h3, 1'h0);
      @(negedge clk);
      chk("standby clk", 16'h2, 16'({analog_power_down, master_clock_output_off}));
      host_model_inst.write_mode(mode_seq_pkg::ADDR_MODE_LO, 3'h5, 1'h0);
      repeat (10) @(negedge clk);
      chk("reserved", 16'h000a, 16'({operating_mode_field, conv_active}));
      t0 = 16'h0040;
      host_model_inst.write_mode(mode_seq_pkg::ADDR_MODE_LO, 3'h2, 1'h0);
      repeat (5) @(negedge clk);
      srst = 1'h1;
      @(negedge clk);
      srst = 1'h0;
      chk("rerun reset", 16'h0001, 16'({operating_mode_field, conv_active, ready_n}));
      print_verdict();
   end
endmodule : tb

/* File: hdl/conv_timer.sv */
// down counter that times one conversion or calibration
`timescale 1ns/1ps
module conv_timer (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // control
   input wire logic abort,
   conv_timer_if.timer tif
);
   typedef struct packed {
      logic [15:0] cnt;
      logic busy;
      logic done;
   } tstate_t;
   tstate_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      if (abort) begin
         s_d.busy = 1'b0;
      end else if (tif.start) begin
         s_d.busy = 1'b1;
         s_d.cnt = (tif.length < mode_seq_pkg::MIN_CONV_CYCLES) ? mode_seq_pkg::MIN_CONV_CYCLES : tif.length;
      end else if (s_q.busy) begin
         if (s_q.cnt == 16'h0001) begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
         end else begin
            s_d.cnt = s_q.cnt - 16'h0001;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tif.done = s_q.done;
endmodule : conv_timer

/* File: hdl/conv_timer_if.sv */
// handshake between the sequencer and its conversion timer
`timescale 1ns/1ps
interface conv_timer_if;
   logic start;
   logic [15:0] length;
   logic done;
   modport ctrl (output start, output length, input done);
   modport timer (input start, input length, output done);
endinterface : conv_timer_if

/* File: hdl/mode_seq.sv */
// operating-mode sequencer of a two-channel converter
// Operation
// - three-bit mode field decodes eight modes
// - write address selects channel for operation
// - self-calibration uses only selected channel's time
// - reset leaves mode field zero, idle
// - calibration and single conversion return idle
// - continuous: update channel, set ready, advance
// - continuous cycles until new mode or reset
// - cycle lasts sum of enabled conversion times plus two cycles per conversion
// - single end: update, ready, pin low, idle
// - single conversion ignores channel enable bit
// - standby powers down converter and buffer
// - standby still answers serial accesses
// - clock-output disable independent of standby
// - self-calibration uses internally shorted inputs
// - mode write clears status, pin high, restarts
// - two write addresses, bit 1 selects channel
// - calibration end: update reg, all ready, idle
`timescale 1ns/1ps
module mode_seq (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // mode register write from the serial interface
   input wire logic mode_wr,
   input wire logic [7:0] mode_wr_addr,
   input wire logic [2:0] mode_wr_field,
   input wire logic mode_wr_clk_off,
   input wire logic serial_access,
   // channel setup
   input wire logic [1:0] ch_enable,
   input wire logic [15:0] ch0_conv_cycles,
   input wire logic [15:0] ch1_conv_cycles,
   // mode register readback
   output logic [2:0] operating_mode_field,
   output logic master_clock_output_off,
   // status
   output logic [1:0] ch_ready,
   output logic ready_n,
   output logic serial_ack,
   // converter control
   output logic conv_active,
   output logic conv_channel,
   output logic analog_power_down,
   output logic inputs_shorted,
   // result strobes
   output logic data_update,
   output logic zero_cal_update,
   output logic full_cal_update,
   output logic self_cal_update
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef enum {ST_IDLE, ST_START, ST_RUN, ST_STANDBY} phase_t;
   typedef struct packed {
      logic [2:0] mode;
      logic clk_off;
      logic ch;
      logic [1:0] rdy;
      logic rdy_n;
      logic ack;
      logic active;
      logic pd;
      logic shorted;
      logic data_upd;
      logic zcal_upd;
      logic fcal_upd;
      logic scal_upd;
   } state_t;
   state_t s_q, s_d;
   phase_t ph_q, ph_d;
   logic abort;
   logic wr_ch;
   logic nxt_ch;
   conv_timer_if tif ();

   conv_timer u_timer (
      .clk(clk),
      .srst(srst),
      .abort(abort),
      .tif(tif)
   );

   assign wr_ch = mode_wr_addr[mode_seq_pkg::ADDR_CH_BIT];
   assign abort = mode_wr;
   // next enabled channel; stays on current if the other is disabled
   assign nxt_ch = ch_enable[~s_q.ch] ? ~s_q.ch : s_q.ch;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      ph_d = ph_q;
      s_d.data_upd = 1'b0;
      s_d.zcal_upd = 1'b0;
      s_d.fcal_upd = 1'b0;
      s_d.scal_upd = 1'b0;
      s_d.ack = serial_access;
      tif.start = 1'b0;
      tif.length = s_q.ch ? ch1_conv_cycles : ch0_conv_cycles;
      if (mode_wr) begin
         s_d.mode = mode_wr_field;
         s_d.clk_off = mode_wr_clk_off;
         s_d.ch = wr_ch;
         s_d.rdy = 2'h0;
         s_d.rdy_n = 1'b1;
         s_d.active = 1'b0;
         s_d.pd = 1'b0;
         s_d.shorted = 1'b0;
         unique case (mode_seq_pkg::op_mode_t'(mode_wr_field))
            mode_seq_pkg::MODE_STANDBY: ph_d = ST_STANDBY;
            mode_seq_pkg::MODE_IDLE, mode_seq_pkg::MODE_RESERVED: ph_d = ST_IDLE;
            default: ph_d = ST_START;
         endcase
      end else begin
         unique case (ph_q)
            ST_IDLE: s_d.active = 1'b0;
            ST_STANDBY: s_d.pd = 1'b1;
            ST_START: begin
               // continuous mode starts on the written channel even if disabled
               tif.start = 1'b1;
               s_d.active = 1'b1;
               s_d.shorted = (s_q.mode == mode_seq_pkg::MODE_SELF_ZERO);
               ph_d = ST_RUN;
            end
            ST_RUN: begin
               if (tif.done) begin
                  unique case (mode_seq_pkg::op_mode_t'(s_q.mode))
                     mode_seq_pkg::MODE_CONT: begin
                        s_d.data_upd = 1'b1;
                        s_d.rdy[s_q.ch] = 1'b1;
                        s_d.rdy_n = 1'b0;
                        s_d.ch = nxt_ch;
                        ph_d = ST_START;
                     end
                     mode_seq_pkg::MODE_SINGLE: begin
                        s_d.data_upd = 1'b1;
                        s_d.rdy[s_q.ch] = 1'b1;
                        s_d.rdy_n = 1'b0;
                        s_d.mode = mode_seq_pkg::MODE_RESET;
                        s_d.active = 1'b0;
                        ph_d = ST_IDLE;
                     end
                     default: begin
                        s_d.zcal_upd = (s_q.mode == mode_seq_pkg::MODE_SYS_ZERO);
                        s_d.fcal_upd = (s_q.mode == mode_seq_pkg::MODE_SYS_FULL);
                        s_d.scal_upd = (s_q.mode == mode_seq_pkg::MODE_SELF_ZERO);
                        s_d.rdy = 2'h3;
                        s_d.rdy_n = 1'b0;
                        s_d.mode = mode_seq_pkg::MODE_RESET;
                        s_d.active = 1'b0;
                        s_d.shorted = 1'b0;
                        ph_d = ST_IDLE;
                     end
                  endcase
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s_q <= '0;
         s_q.rdy_n <= 1'b1;
         s_q.mode <= mode_seq_pkg::MODE_RESET;
         ph_q <= ST_IDLE;
      end else begin
         s_q <= s_d;
         ph_q <= ph_d;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign operating_mode_field = s_q.mode;
   assign master_clock_output_off = s_q.clk_off;
   assign ch_ready = s_q.rdy;
   assign ready_n = s_q.rdy_n;
   assign serial_ack = s_q.ack;
   assign conv_active = s_q.active;
   assign conv_channel = s_q.ch;
   assign analog_power_down = s_q.pd;
   assign inputs_shorted = s_q.shorted;
   assign data_update = s_q.data_upd;
   assign zero_cal_update = s_q.zcal_upd;
   assign full_cal_update = s_q.fcal_upd;
   assign self_cal_update = s_q.scal_upd;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_mode_write;
      mode_wr;
   endsequence
   sequence s_cleared;
      ready_n && ch_ready == 2'h0;
   endsequence
   chk_write_clears_status: assert property (@(posedge clk) disable iff (srst)
      s_mode_write |=> s_cleared) else $error("mode write did not clear status");
   chk_write_loads_mode: assert property (@(posedge clk) disable iff (srst)
      mode_wr |=> operating_mode_field == $past(mode_wr_field)) else $error("mode not loaded");
   chk_write_channel: assert property (@(posedge clk) disable iff (srst)
      mode_wr |=> conv_channel == $past(mode_wr_addr[1])) else $error("channel not taken from address");
   chk_reset_idle: assert property (@(posedge clk)
      srst |=> operating_mode_field == 3'h0 && !conv_active) else $error("reset not idle");
   chk_single_end: assert property (@(posedge clk) disable iff (srst)
      data_update && operating_mode_field == 3'h0 |-> !ready_n) else $error("single end without ready");
   chk_cal_all_ready: assert property (@(posedge clk) disable iff (srst)
      (zero_cal_update || full_cal_update || self_cal_update) |-> ch_ready == 2'h3 && !ready_n
      && operating_mode_field == 3'h0) else $error("calibration end wrong");
   chk_standby_power: assert property (@(posedge clk) disable iff (srst)
      mode_wr && mode_wr_field == 3'h3 |=> ##1 analog_power_down || $past(mode_wr)) else $error("standby no power down");
   chk_reserved_idle: assert property (@(posedge clk) disable iff (srst)
      mode_wr && mode_wr_field == 3'h5 ##1 !mode_wr [*2] |-> !conv_active) else $error("reserved mode converts");
   chk_self_cal_short: assert property (@(posedge clk) disable iff (srst)
      conv_active && operating_mode_field == 3'h4 |-> inputs_shorted) else $error("self cal not shorted");
   chk_clk_off_kept: assert property (@(posedge clk) disable iff (srst)
      !mode_wr |=> master_clock_output_off == $past(master_clock_output_off)) else $error("clock off changed");
endmodule : mode_seq

/* File: hdl/mode_seq_pkg.sv */
// shared constants and types of the operating-mode sequencer
package mode_seq_pkg;
   localparam int NUM_CH = 2;
   localparam int TIME_W = 16;
   typedef enum logic [2:0] {
      MODE_IDLE = 3'h0,
      MODE_CONT = 3'h1,
      MODE_SINGLE = 3'h2,
      MODE_STANDBY = 3'h3,
      MODE_SELF_ZERO = 3'h4,
      MODE_RESERVED = 3'h5,
      MODE_SYS_ZERO = 3'h6,
      MODE_SYS_FULL = 3'h7
   } op_mode_t;
   localparam logic [2:0] MODE_RESET = 3'h0;
   localparam logic [7:0] ADDR_MODE_LO = 8'h38;
   localparam logic [7:0] ADDR_MODE_HI = 8'h3a;
   localparam int ADDR_CH_BIT = 1;
   localparam logic [TIME_W-1:0] MIN_CONV_CYCLES = 16'h0001;
endpackage : mode_seq_pkg
